// [pkg/ivr_pkg.sv]
/*
  Constants, source table and register map of the interrupt vector and reset map block.
  Assumes one 100 MHz bus clock and 32-bit APB data, one aligned word per register.
*/
// Summary of operation
// - timer one accumulator overflow goes to FFAC, enabled locally, elevation code AC
// - timer one accumulator edge goes to FFAA, I-bit masked, locally enabled, code AA
// - timer two channels 4..7 at FFA6..FFA0, overflow FF9E, code is vector low byte
// - timer two accumulator overflow goes to FF9C, I-bit masked, locally enabled
// - timer two accumulator edge goes to FF9A, I-bit masked, locally enabled
// - modulator reloads A..C at FF98..FF94, faults 0..3 at FF92..FF8C, each enabled
// - low-voltage indication at FF8A, emergency shutdown at FF88, masked and enabled
// - reset sources use the same vector scheme as interrupts
// - por, pin and low-voltage reset FFFE first, clock monitor FFFC, watchdog FFFA
// - any reset forces every register and control bit to a defined value; here only rst_b does, reset sources set just the reset vector, its priority and event
// - on-chip RAM keeps its contents through reset and has no initial value
// - vector FFFE has no mask bit and no local enable
package ivr_pkg;
  localparam int NUM_SRC = 18;
  localparam logic [7:0] VEC_PAGE = 8'hFF;
  localparam logic [7:0] CODE_FIRST = 8'hAC;
  localparam logic [7:0] CODE_GROUP2 = 8'hA6;
  localparam int GROUP2_IDX = 2;
  localparam logic [7:0] CODE_POR = 8'hFE;
  localparam logic [7:0] CODE_CLKMON = 8'hFC;
  localparam logic [7:0] CODE_WDOG = 8'hFA;
  localparam logic [1:0] PRIO_POR = 2'h1;
  localparam logic [1:0] PRIO_CLKMON = 2'h2;
  localparam logic [1:0] PRIO_WDOG = 2'h3;
  localparam logic [7:0] OFS_ELEV = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_REQ = 8'h08;
  localparam logic [7:0] OFS_VECTOR = 8'h0C;
  localparam logic [7:0] OFS_RSTVEC = 8'h10;
  localparam logic [7:0] OFS_EVT = 8'h14;
  localparam logic [7:0] OFS_EVT_MASK = 8'h18;
  localparam logic [7:0] OFS_RAM = 8'h20;
  localparam int RAM_WORDS = 4;
  localparam logic [7:0] ELEV_RST = 8'hF2;
  localparam logic [NUM_SRC-1:0] ENABLE_RST = 18'h00000;
  localparam logic [15:0] RSTVEC_RST = 16'hFFFE;
  localparam int EVT_W = 2;
  localparam int EVT_ACK_BIT = 0;
  localparam int EVT_RST_BIT = 1;
  localparam logic [EVT_W-1:0] EVT_RST = 2'h0;
  localparam int VEC_PEND_BIT = 16;
  typedef enum {IRQ_IDLE, IRQ_ASSERT} ivr_irq_state_type;

  // source 0 is the highest default priority; slot A8 is reserved
  function automatic logic [7:0] src_code(input int i);
    if (i < GROUP2_IDX) begin
      return CODE_FIRST - 8'(2 * i);
    end
    return CODE_GROUP2 - 8'(2 * (i - GROUP2_IDX));
  endfunction
endpackage

// [pkg/ivr_sel_if.sv]
/*
  Interface between the register block and the priority encoder.
  Assumes the encoder answers combinationally within the cycle.
*/
`timescale 1ns/1ps
interface ivr_sel_if #(parameter int N = 18);
  logic [N-1:0] active;
  logic [7:0] elevate;
  logic hit;
  logic [7:0] code;
  modport enc (input active, input elevate, output hit, output code);
  modport user (output active, output elevate, input hit, input code);
endinterface

// [verilog/ivr_prio_enc.sv]
/*
  Priority encoder: picks the active source with the highest default priority,
  unless the elevation code names an active source. Assumes gated requests.
*/
`timescale 1ns/1ps
module ivr_prio_enc #(parameter int N = 18) (
  ivr_sel_if.enc sel
);
  import ivr_pkg::*;

  always_comb begin
    sel.hit = 1'b0;
    sel.code = 8'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (sel.active[i]) begin
        sel.hit = 1'b1;
        sel.code = src_code(i);
      end
    end
    // elevated source overrides the default order
    for (int i = 0; i < N; i++) begin
      if (sel.active[i] && src_code(i) == sel.elevate) begin
        sel.code = src_code(i);
      end
    end
  end
endmodule

// [verilog/ivr_reset_sel.sv]
/*
  Reset source arbiter: turns the reset source levels into a vector code
  and priority. Assumes levels synchronous to the bus clock.
*/
`timescale 1ns/1ps
module ivr_reset_sel (
  input wire logic por,
  input wire logic ext,
  input wire logic lvr,
  input wire logic clkmon,
  input wire logic wdog,
  output logic valid,
  output logic [7:0] code,
  output logic [1:0] prio
);
  import ivr_pkg::*;

  always_comb begin
    valid = por | ext | lvr | clkmon | wdog;
    code = CODE_POR;
    prio = PRIO_POR;
    // no mask and no enable take part on the first vector
    if (por || ext || lvr) begin
      code = CODE_POR;
      prio = PRIO_POR;
    end else if (clkmon) begin
      code = CODE_CLKMON;
      prio = PRIO_CLKMON;
    end else if (wdog) begin
      code = CODE_WDOG;
      prio = PRIO_WDOG;
    end
  end
endmodule

// [verilog/ivr_top.sv]
/*
  Interrupt vector and reset map: gates peripheral requests with local enables
  and the CPU mask flag, presents the winning vector to the CPU, tracks the
  reset vector, and offers an APB register file with a small scratch RAM.
  Assumes all inputs synchronous to clk_sys and a CPU that pulses cpu_vec_ack.
*/
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module ivr_top #(
  parameter int N = ivr_pkg::NUM_SRC,
  parameter int WORDS = ivr_pkg::RAM_WORDS
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [N-1:0] src_req,
  input wire logic cpu_i_bit,
  input wire logic cpu_vec_ack,
  input wire logic rst_src_por,
  input wire logic rst_src_ext,
  input wire logic rst_src_lvr,
  input wire logic rst_src_clkmon,
  input wire logic rst_src_wdog,
  output logic irq_cpu,
  output logic [15:0] irq_vector,
  output logic [15:0] reset_vector,
  output logic irq_evt
);
  import ivr_pkg::*;

  ivr_sel_if #(.N(N)) sel ();

  logic [7:0] elev_q, elev_d;
  logic [N-1:0] en_q, en_d;
  logic [EVT_W-1:0] evt_q, evt_d;
  logic [EVT_W-1:0] evt_mask_q, evt_mask_d;
  logic [EVT_W-1:0] evt_set;
  ivr_irq_state_type st_q, st_d;
  logic [15:0] vec_q, vec_d;
  logic [15:0] rvec_q, rvec_d;
  logic [1:0] rprio_q, rprio_d;
  logic irq_q, irq_d;
  logic irq_evt_q, irq_evt_d;
  logic [31:0] rd_q, rd_d;
  logic rdy_q, rdy_d;
  logic err_q, err_d;
  logic [31:0] ram_q [WORDS];
  logic rst_valid;
  logic [7:0] rst_code;
  logic [1:0] rst_prio;
  logic setup;
  logic access;
  logic wr_hit;
  logic rd_clr;

  function automatic logic is_mapped(input logic [7:0] a);
    logic ram_hit;
    ram_hit = a >= OFS_RAM && a < OFS_RAM + 8'(4 * WORDS);
    return a[1:0] == 2'h0 && (a <= OFS_EVT_MASK || ram_hit);
  endfunction

  ivr_prio_enc #(.N(N)) u_enc (
    .sel(sel.enc)
  );

  ivr_reset_sel u_rsel (
    .por(rst_src_por),
    .ext(rst_src_ext),
    .lvr(rst_src_lvr),
    .clkmon(rst_src_clkmon),
    .wdog(rst_src_wdog),
    .valid(rst_valid),
    .code(rst_code),
    .prio(rst_prio)
  );

  // requests only compete once their local enable is set
  assign sel.active = src_req & en_q;
  assign sel.elevate = elev_q;

  assign setup = psel && !penable;
  assign access = psel && penable && rdy_q;
  assign wr_hit = access && pwrite && !err_q;
  assign rd_clr = access && !pwrite && paddr == OFS_EVT;

  // APB: zero wait states, data and error prepared in the setup cycle
  always_comb begin
    rd_d = 32'h0000_0000;
    rdy_d = setup;
    err_d = setup && !is_mapped(paddr);
    if (setup && !pwrite && is_mapped(paddr)) begin
      case (paddr)
        OFS_ELEV: rd_d = {24'h00_0000, elev_q};
        OFS_ENABLE: rd_d = 32'(en_q);
        OFS_REQ: rd_d = 32'(src_req);
        OFS_VECTOR: rd_d = {15'h0000, irq_q, vec_q};
        OFS_RSTVEC: rd_d = {14'h0000, rprio_q, rvec_q};
        OFS_EVT: rd_d = 32'(evt_q);
        OFS_EVT_MASK: rd_d = 32'(evt_mask_q);
        default: rd_d = ram_q[paddr[3:2]];
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rd_q <= 32'h0000_0000;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
    end
  end

  // scratch RAM has no reset; software must initialise it itself
  always_ff @(posedge clk_sys) begin
    if (wr_hit && paddr >= OFS_RAM) begin
      ram_q[paddr[3:2]] <= pwdata;
    end
  end

  // software-steered configuration
  always_comb begin
    elev_d = elev_q;
    en_d = en_q;
    evt_mask_d = evt_mask_q;
    if (wr_hit) begin
      case (paddr)
        OFS_ELEV: elev_d = pwdata[7:0];
        OFS_ENABLE: en_d = pwdata[N-1:0];
        OFS_EVT_MASK: evt_mask_d = pwdata[EVT_W-1:0];
        default: elev_d = elev_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      elev_q <= ELEV_RST;
      en_q <= ENABLE_RST;
      evt_mask_q <= EVT_RST;
    end else begin
      elev_q <= elev_d;
      en_q <= en_d;
      evt_mask_q <= evt_mask_d;
    end
  end

  // vector stays frozen while asserted so the CPU fetch sees one value
  always_comb begin
    st_d = st_q;
    vec_d = vec_q;
    case (st_q)
      IRQ_IDLE: begin
        if (sel.hit && !cpu_i_bit) begin
          st_d = IRQ_ASSERT;
          vec_d = {VEC_PAGE, sel.code};
        end
      end
      IRQ_ASSERT: begin
        if (cpu_vec_ack || cpu_i_bit || !sel.hit) begin
          st_d = IRQ_IDLE;
        end
      end
      default: st_d = IRQ_IDLE;
    endcase
    irq_d = st_d == IRQ_ASSERT;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_q <= IRQ_IDLE;
      vec_q <= 16'h0000;
      irq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      vec_q <= vec_d;
      irq_q <= irq_d;
    end
  end

  // reset sources share the interrupt vector page
  always_comb begin
    rvec_d = rvec_q;
    rprio_d = rprio_q;
    if (rst_valid) begin
      rvec_d = {VEC_PAGE, rst_code};
      rprio_d = rst_prio;
    end
  end

  // sticky events: set wins over the read clear in the same cycle
  always_comb begin
    evt_set = '0;
    evt_set[EVT_ACK_BIT] = st_q == IRQ_ASSERT && cpu_vec_ack;
    evt_set[EVT_RST_BIT] = rst_valid;
    evt_d = (rd_clr ? '0 : evt_q) | evt_set;
    irq_evt_d = |(evt_d & evt_mask_q);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rvec_q <= RSTVEC_RST;
      rprio_q <= PRIO_POR;
      evt_q <= EVT_RST;
      irq_evt_q <= 1'b0;
    end else begin
      rvec_q <= rvec_d;
      rprio_q <= rprio_d;
      evt_q <= evt_d;
      irq_evt_q <= irq_evt_d;
    end
  end

  assign prdata = rd_q;
  assign pready = rdy_q;
  assign pslverr = err_q;
  assign irq_cpu = irq_q;
  assign irq_vector = vec_q;
  assign reset_vector = rvec_q;
  assign irq_evt = irq_evt_q;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  logic elev_hit;
  always_comb begin
    elev_hit = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (sel.active[i] && src_code(i) == elev_q) begin
        elev_hit = 1'b1;
      end
    end
  end

  AST_IRQ_UNMASKED: assert property ($rose(irq_cpu) |-> $past(!cpu_i_bit))
    else $error("interrupt raised while the mask flag was set");
  AST_VEC_PAGE: assert property (irq_cpu |-> irq_vector[15:8] == 8'hFF)
    else $error("vector outside the vector page");
  AST_VEC_HOLD: assert property (irq_cpu && $past(irq_cpu) |-> $stable(irq_vector))
    else $error("vector changed while asserted");
  AST_ACK_DROP: assert property (irq_cpu && cpu_vec_ack |=> !irq_cpu)
    else $error("interrupt held after vector fetch");
  AST_ENABLE_GATE: assert property ($rose(irq_cpu) |-> $past(|(src_req & en_q)))
    else $error("interrupt without an enabled request");
  AST_T1_PA_OVF: assert property ($rose(irq_cpu) && irq_vector == 16'hFFAC
      |-> $past(src_req[0] && en_q[0]))
    else $error("vector FFAC without its request");
  AST_T1_PA_EDGE: assert property ($rose(irq_cpu) && irq_vector == 16'hFFAA
      |-> $past(src_req[1] && en_q[1]))
    else $error("vector FFAA without its request");
  AST_T2_CH4: assert property ($rose(irq_cpu) && irq_vector == 16'hFFA6
      |-> $past(src_req[2] && en_q[2]))
    else $error("vector FFA6 without its request");
  AST_T2_PA_OVF: assert property ($rose(irq_cpu) && irq_vector == 16'hFF9C
      |-> $past(src_req[7] && en_q[7]))
    else $error("vector FF9C without its request");
  AST_T2_PA_EDGE: assert property ($rose(irq_cpu) && irq_vector == 16'hFF9A
      |-> $past(src_req[8] && en_q[8]))
    else $error("vector FF9A without its request");
  AST_FAULT0: assert property ($rose(irq_cpu) && irq_vector == 16'hFF92
      |-> $past(src_req[12] && en_q[12]))
    else $error("vector FF92 without its request");
  AST_LOW_VOLT: assert property ($rose(irq_cpu) && irq_vector == 16'hFF8A
      |-> $past(src_req[16] && en_q[16]))
    else $error("vector FF8A without its request");
  AST_SHUTDOWN: assert property ($rose(irq_cpu) && irq_vector == 16'hFF88
      |-> $past(src_req[17] && en_q[17]))
    else $error("vector FF88 without its request");
  AST_ELEVATE: assert property (sel.hit && elev_hit |-> sel.code == elev_q)
    else $error("elevated source did not win");
  AST_MASK_HOLD: assert property (cpu_i_bit |=> !irq_cpu)
    else $error("interrupt shown while masked");
  AST_RESET_FIRST: assert property (rst_src_por || rst_src_ext || rst_src_lvr
      |=> reset_vector == 16'hFFFE)
    else $error("first reset vector not taken");
  AST_RESET_CLKMON: assert property (rst_src_clkmon && !rst_src_por && !rst_src_ext
      && !rst_src_lvr |=> reset_vector == 16'hFFFC)
    else $error("clock monitor reset vector wrong");
  AST_RESET_WDOG: assert property (rst_src_wdog && !rst_src_clkmon && !rst_src_por
      && !rst_src_ext && !rst_src_lvr |=> reset_vector == 16'hFFFA ##0 $stable(elev_q))
    else $error("watchdog reset vector wrong");
  AST_RESET_STATE: assert property (!$past(rst_b) |-> reset_vector == 16'hFFFE
      && !irq_cpu && en_q == '0 && evt_q == '0)
    else $error("state not defined after reset");
  // unwritten RAM holds unknowns, so compare by stability rather than equality
  AST_RAM_KEPT: assert property (@(posedge clk_sys) disable iff (1'b0)
      !rst_b && !wr_hit |=> $stable(ram_q[0]))
    else $error("RAM changed by reset");
  AST_SET_WINS: assert property (rd_clr && rst_valid |=> evt_q[EVT_RST_BIT])
    else $error("event lost on clear");

  COV_DELIVER: cover property ($rose(irq_cpu) ##[1:8] cpu_vec_ack);
  COV_ELEVATE: cover property (sel.hit && elev_hit && sel.code != src_code(0));
  COV_WDOG: cover property (rst_src_wdog && !rst_src_por);
  COV_RDCLR: cover property (rd_clr && evt_q != '0);
endmodule

// [verif/ivr_cpu_model.sv]
/*
  CPU core model: fetches the vector and pulses cpu_vec_ack for one cycle.
  Assumes irq_cpu is registered; lag sets how many cycles the fetch takes.
*/
`timescale 1ns/1ps
module ivr_cpu_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic irq_cpu,
  input wire logic [3:0] lag,
  output logic cpu_vec_ack
);
  logic [3:0] cnt_q;
  // no new fetch in the ack cycle: irq_cpu still stands then
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_q <= 4'h0;
      cpu_vec_ack <= 1'b0;
    end else begin
      cpu_vec_ack <= 1'b0;
      cnt_q <= 4'h0;
      if (irq_cpu && !cpu_vec_ack) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == lag) begin
          cpu_vec_ack <= 1'b1;
          cnt_q <= 4'h0;
        end
      end
    end
  end
endmodule

// [verif/interrupt_vector_and_reset_map_tb.sv]
/*
  Self-checking bench for the vector and reset map: APB master, request
  and reset source stimulus, CPU model. Assumes the APB map of the package.
*/
`timescale 1ns/1ps
module interrupt_vector_and_reset_map_tb;
  import ivr_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, cpu_vec_ack, irq_cpu, irq_evt;
  logic cpu_i_bit = 1'b0;
  logic [NUM_SRC-1:0] src_req = '0;
  logic [4:0] rsrc = 5'h00;
  logic [15:0] irq_vector, reset_vector;
  logic [3:0] lag = 4'h0;
  int failures = 0;
  int total_checks = 0;
  always #5 clk_sys = ~clk_sys;
  ivr_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_req(src_req), .cpu_i_bit(cpu_i_bit),
    .cpu_vec_ack(cpu_vec_ack), .rst_src_por(rsrc[0]), .rst_src_ext(rsrc[1]),
    .rst_src_lvr(rsrc[2]), .rst_src_clkmon(rsrc[3]), .rst_src_wdog(rsrc[4]),
    .irq_cpu(irq_cpu), .irq_vector(irq_vector), .reset_vector(reset_vector),
    .irq_evt(irq_evt));
  ivr_cpu_model cpu (.clk_sys(clk_sys), .rst_b(rst_b), .irq_cpu(irq_cpu), .lag(lag),
    .cpu_vec_ack(cpu_vec_ack));
  task automatic give_verdict();
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %08h expected %08h", $time, seen, exp);
    end
  endtask
  // the answer is taken at the edge where pready is seen high, before it updates
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (irq_cpu !== lvl && n < 40);
    chk(irq_cpu, lvl);
  endtask
  function automatic logic [15:0] exp_vec(input int i);
    return {8'hFF, (i < 2) ? 8'hAC - 8'(2 * i) : 8'hA6 - 8'(2 * (i - 2))};
  endfunction
  task automatic t_reset_values();
    apb(1'b0, OFS_ELEV, 32'h0);
    chk(rd, 32'h000000F2);
    apb(1'b0, OFS_ENABLE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_EVT_MASK, 32'h0);
    chk(rd, 32'h0);
    chk({irq_cpu, irq_evt, reset_vector}, 32'h0000FFFE);
  endtask
  // every source alone, with prompt and slow fetches
  task automatic t_vectors();
    apb(1'b1, OFS_ENABLE, 32'h0003FFFF);
    for (int i = 0; i < NUM_SRC; i++) begin
      lag <= 4'(i % 3);
      src_req <= 18'h1 << i;
      wait_irq(1'b1);
      chk(irq_vector, exp_vec(i));
      src_req <= '0;
      wait_irq(1'b0);
    end
  endtask
  task automatic t_masking();
    src_req <= 18'h00080;
    cpu_i_bit <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk(irq_cpu, 1'b0);
    apb(1'b0, OFS_REQ, 32'h0);
    chk(rd, 32'h00000080);
    apb(1'b1, OFS_ENABLE, 32'h0003FF7F);
    cpu_i_bit <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(irq_cpu, 1'b0);
    lag <= 4'hF;
    apb(1'b1, OFS_ENABLE, 32'h0003FFFF);
    wait_irq(1'b1);
    chk(irq_vector, 16'hFF9C);
    apb(1'b0, OFS_VECTOR, 32'h0);
    chk(rd, 32'h0001FF9C);
    src_req <= '0;
    wait_irq(1'b0);
  endtask
  // elevation picks a named active source, else the lowest index wins
  task automatic t_elevation();
    logic [7:0] el;
    for (int k = 0; k < 3; k++) begin
      el = (k == 0) ? 8'h88 : (k == 1) ? 8'h9C : 8'hF2;
      apb(1'b1, OFS_ELEV, {24'h0, el});
      src_req <= 18'h20081;
      wait_irq(1'b1);
      chk(irq_vector, (k == 2) ? 16'hFFAC : {8'hFF, el});
      src_req <= '0;
      wait_irq(1'b0);
    end
  endtask
  // all combinations of reset sources, one cycle each
  task automatic t_reset_sources();
    logic [17:0] e;
    for (int m = 1; m < 32; m++) begin
      e = (m[2:0] != 0) ? 18'h1FFFE : m[3] ? 18'h2FFFC : 18'h3FFFA;
      rsrc <= 5'(m);
      @(posedge clk_sys);
      rsrc <= 5'h00;
      @(posedge clk_sys);
      chk(reset_vector, e[15:0]);
      apb(1'b0, OFS_RSTVEC, 32'h0);
      chk(rd, {14'h0, e});
    end
  endtask
  task automatic t_events();
    repeat (2) @(posedge clk_sys);
    chk(irq_evt, 1'b0);
    apb(1'b1, OFS_EVT_MASK, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk(irq_evt, 1'b1);
    rsrc <= 5'h10;
    apb(1'b0, OFS_EVT, 32'h0);
    chk(rd, 32'h3);
    rsrc <= 5'h00;
    apb(1'b0, OFS_EVT, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, OFS_EVT, 32'h0);
    chk(rd, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk(irq_evt, 1'b0);
  endtask
  // scratch RAM must survive a reset that clears the registers
  task automatic t_ram_and_map();
    apb(1'b1, OFS_RAM, 32'h5A5A1234);
    apb(1'b1, OFS_RAM + 8'h0C, 32'hC3C30F0F);
    apb(1'b1, OFS_ELEV, 32'h9A);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    apb(1'b0, OFS_RAM, 32'h0);
    chk(rd, 32'h5A5A1234);
    apb(1'b0, OFS_RAM + 8'h0C, 32'h0);
    chk(rd, 32'hC3C30F0F);
    apb(1'b0, OFS_ELEV, 32'h0);
    chk(rd, 32'h000000F2);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(err), 32'h00000001);
    chk(rd, 32'h00000000);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset_values();
    t_vectors();
    t_masking();
    t_elevation();
    t_reset_sources();
    t_events();
    t_ram_and_map();
    give_verdict();
  end
  initial begin
    #200000;
    failures++;
    give_verdict();
  end
endmodule
